// ===== alu_address_former.sv
// alu_address_former: forms the 20-bit operand address
// assumes: parts come from the sequencer
`timescale 1ns/1ps
`default_nettype none
module alu_address_former (
   input wire logic use_bank,
   input wire logic [3:0] upper_bank_register,
   input wire logic [15:0] offset,
   output logic [19:0] address
);
   always_comb begin
      address = {(use_bank ? upper_bank_register : 4'h0), offset};
   end
endmodule : alu_address_former
`default_nettype wire

// ===== alu_cycle_timer.sv
// alu_cycle_timer: clock count for each operation and source form
// assumes: read when an op is taken
`timescale 1ns/1ps
`default_nettype none
module alu_cycle_timer (
   input wire alu_pkg::alu_op_t op,
   input wire alu_pkg::alu_src_t src,
   output logic [2:0] cycles
);
   function automatic logic is_word(input alu_pkg::alu_op_t o);
      is_word = (o == alu_pkg::op_word_add) ||
         (o == alu_pkg::op_word_subtract) ||
         (o == alu_pkg::op_word_compare);
   endfunction : is_word

   always_comb begin
      cycles = alu_pkg::cyc_byte_ram;
      if (op == alu_pkg::op_unsigned_multiply) begin
         cycles = alu_pkg::cyc_multiply;
      end else if (op == alu_pkg::op_word_logical_right_shift ||
         op == alu_pkg::op_word_left_shift ||
         op == alu_pkg::op_word_arith_right_shift) begin
         cycles = alu_pkg::cyc_word_shift;
      end else if (op == alu_pkg::op_logical_right_shift ||
         op == alu_pkg::op_left_shift ||
         op == alu_pkg::op_arith_right_shift) begin
         cycles = alu_pkg::cyc_byte_shift;
      end else if (op == alu_pkg::op_word_increment ||
         op == alu_pkg::op_word_decrement) begin
         unique case (src)
            alu_pkg::src_reg: cycles = alu_pkg::cyc_word_incdec_reg;
            alu_pkg::src_ext_ram, alu_pkg::src_ext_flash:
               cycles = alu_pkg::cyc_word_incdec_ext;
            default: cycles = alu_pkg::cyc_word_incdec_mem;
         endcase
      end else if (is_word(op)) begin
         unique case (src)
            alu_pkg::src_flash: cycles = alu_pkg::cyc_word_flash;
            alu_pkg::src_ext_ram: cycles = alu_pkg::cyc_word_ext_ram;
            alu_pkg::src_ext_flash: cycles = alu_pkg::cyc_word_ext_flash;
            default: cycles = alu_pkg::cyc_word_ram;
         endcase
      end else begin
         unique case (src)
            alu_pkg::src_flash: cycles = alu_pkg::cyc_byte_flash;
            alu_pkg::src_ext_ram: cycles = alu_pkg::cyc_byte_ext_ram;
            alu_pkg::src_ext_flash: cycles = alu_pkg::cyc_byte_ext_flash;
            alu_pkg::src_saddr_imm: cycles = alu_pkg::cyc_saddr_imm;
            default: cycles = alu_pkg::cyc_byte_ram;
         endcase
      end
   end
endmodule : alu_cycle_timer
`default_nettype wire

// ===== alu_datapath.sv
// alu_datapath: arithmetic, logic, multiply and shift unit of the cpu
// assumes: start is a one-cycle pulse with operands valid
// Operation
// - subtract with borrow: acc minus operand minus carry; Z AC CY; 1 clock
// - short-area immediate form writes memory, not acc; 2 clocks
// - AND stores result, updates only zero flag
// - OR stores result, updates only zero flag
// - XOR stores result, updates only zero flag
// - compare subtracts, discards result, sets Z AC CY; 1 clock
// - compare with zero sets Z, clears AC and CY
// - index compare: index byte minus pointer byte; 1 or 4 clocks
// - word add into pair, all flags; ext form 3 or 6 clocks
// - word subtract into pair, all flags
// - word compare keeps pair, all flags; immediate 2 clocks
// - unsigned multiply acc by index byte into pair, 2 clocks, no flags
// - byte inc/dec writes back, updates Z and AC, keeps carry
// - word inc/dec touches no flag; register 2, memory 4, ext memory 5 clocks
// - logical right shift, bit 0 to carry, 0 into bit 7, 1 clock
// - left shift, bit 7 to carry, 0 into bit 0, 1 clock
// - arithmetic right shift keeps bit 7, bit 0 to carry
// - word shifts use bits 0 and 15, 2 clocks, carry only
// - flash byte operand takes 4 clocks instead of 1
`timescale 1ns/1ps
`default_nettype none
module alu_datapath #(
   parameter int data_w = 8,
   parameter int count_w = 4
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic start,
   input wire alu_pkg::alu_op_t op,
   input wire alu_pkg::alu_src_t src,
   input wire logic [15:0] operand_a,
   input wire logic [15:0] operand_b,
   input wire logic [count_w-1:0] shift_count,
   input wire logic zero_flag_in,
   input wire logic half_carry_flag_in,
   input wire logic carry_flag_in,
   input wire logic [3:0] upper_bank_register,
   input wire logic [15:0] address_offset,
   output logic busy,
   output logic done,
   output logic [15:0] result,
   output logic write_accumulator,
   output logic write_memory,
   output logic write_pair,
   output logic zero_flag,
   output logic half_carry_flag,
   output logic carry_flag,
   output logic [19:0] operand_address
);

   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic busy;
      logic done;
      logic [2:0] count;
      logic [15:0] result;
      logic wr_acc;
      logic wr_mem;
      logic wr_pair;
      logic z;
      logic ac;
      logic cy;
      logic [19:0] addr;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [2:0] cycles;
   logic [19:0] address;
   logic use_bank;

   assign use_bank = (src == alu_pkg::src_ext_ram) ||
      (src == alu_pkg::src_ext_flash);

   alu_cycle_timer timer (
      .op(op),
      .src(src),
      .cycles(cycles)
   );

   alu_address_former addr_former (
      .use_bank(use_bank),
      .upper_bank_register(upper_bank_register),
      .offset(address_offset),
      .address(address)
   );

   ////////////////////////////////////////////////////////////////////
   // a - b - borrow, returning {carry, half, diff}
   function automatic logic [17:0] sub_w(input logic [15:0] a,
      input logic [15:0] b, input logic bin, input logic wide);
      logic [16:0] d;
      logic [4:0] h;
      logic msb_borrow;
      d = {1'b0, a} - {1'b0, b} - {16'h0000, bin};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      if (wide) begin
         msb_borrow = d[16];
      end else begin
         msb_borrow = ({1'b0, a[7:0]} - {1'b0, b[7:0]} -
            {8'h00, bin}) >> 8 != 9'h000;
      end
      sub_w = {msb_borrow, h[alu_pkg::half_bit], d[15:0]};
   endfunction : sub_w

   function automatic logic [17:0] add_w(input logic [15:0] a,
      input logic [15:0] b, input logic wide);
      logic [16:0] s;
      logic [4:0] h;
      logic [8:0] s8;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
      add_w = {(wide ? s[16] : s8[8]), h[alu_pkg::half_bit], s[15:0]};
   endfunction : add_w

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [17:0] r;
      logic [15:0] v;
      logic [7:0] b;
      logic c;
      r = 18'h00000;
      v = 16'h0000;
      b = 8'h00;
      c = carry_flag_in;
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (st_r.busy) begin
         st_nxt.count = st_r.count - 3'h1;
         if (st_r.count == 3'h1) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end
      end else if (start) begin
         st_nxt.busy = (cycles != 3'h1);
         st_nxt.done = (cycles == 3'h1);
         st_nxt.count = cycles - 3'h1;
         st_nxt.addr = address;
         st_nxt.wr_acc = 1'b0;
         st_nxt.wr_mem = 1'b0;
         st_nxt.wr_pair = 1'b0;
         st_nxt.z = zero_flag_in;
         st_nxt.ac = half_carry_flag_in;
         st_nxt.cy = carry_flag_in;
         unique case (op)
            alu_pkg::op_subtract_with_borrow,
            alu_pkg::op_compare,
            alu_pkg::op_index_compare: begin
               r = sub_w({8'h00, operand_a[7:0]}, {8'h00, operand_b[7:0]},
                  (op == alu_pkg::op_subtract_with_borrow) & carry_flag_in,
                  1'b0);
               st_nxt.result = {8'h00, r[7:0]};
               st_nxt.z = (r[7:0] == alu_pkg::zero_byte);
               st_nxt.ac = r[16];
               st_nxt.cy = r[17];
               if (op == alu_pkg::op_subtract_with_borrow) begin
                  st_nxt.wr_mem = (src == alu_pkg::src_saddr_imm);
                  st_nxt.wr_acc = (src != alu_pkg::src_saddr_imm);
               end
            end
            alu_pkg::op_and, alu_pkg::op_or, alu_pkg::op_xor: begin
               unique case (op)
                  alu_pkg::op_and: b = operand_a[7:0] & operand_b[7:0];
                  alu_pkg::op_or: b = operand_a[7:0] | operand_b[7:0];
                  default: b = operand_a[7:0] ^ operand_b[7:0];
               endcase
               st_nxt.result = {8'h00, b};
               st_nxt.z = (b == alu_pkg::zero_byte);
               st_nxt.wr_mem = (src == alu_pkg::src_saddr_imm);
               st_nxt.wr_acc = (src != alu_pkg::src_saddr_imm);
            end
            alu_pkg::op_compare_with_zero: begin
               st_nxt.z = (operand_a[7:0] == alu_pkg::zero_byte);
               st_nxt.ac = 1'b0;
               st_nxt.cy = 1'b0;
            end
            alu_pkg::op_word_add: begin
               r = add_w(operand_a, operand_b, 1'b1);
               st_nxt.result = r[15:0];
               st_nxt.z = (r[15:0] == 16'h0000);
               st_nxt.ac = r[16];
               st_nxt.cy = r[17];
               st_nxt.wr_pair = 1'b1;
            end
            alu_pkg::op_word_subtract, alu_pkg::op_word_compare: begin
               r = sub_w(operand_a, operand_b, 1'b0, 1'b1);
               st_nxt.result = r[15:0];
               st_nxt.z = (r[15:0] == 16'h0000);
               st_nxt.ac = r[16];
               st_nxt.cy = r[17];
               st_nxt.wr_pair = (op == alu_pkg::op_word_subtract);
            end
            alu_pkg::op_unsigned_multiply: begin
               st_nxt.result = 16'(operand_a[7:0]) * 16'(operand_b[7:0]);
               st_nxt.wr_pair = 1'b1;
            end
            alu_pkg::op_increment, alu_pkg::op_decrement: begin
               if (op == alu_pkg::op_increment) begin
                  r = add_w({8'h00, operand_a[7:0]}, 16'h0001, 1'b0);
               end else begin
                  r = sub_w({8'h00, operand_a[7:0]}, 16'h0001, 1'b0, 1'b0);
               end
               st_nxt.result = {8'h00, r[7:0]};
               st_nxt.z = (r[7:0] == alu_pkg::zero_byte);
               st_nxt.ac = r[16];
               st_nxt.wr_acc = (src == alu_pkg::src_reg);
               st_nxt.wr_mem = (src != alu_pkg::src_reg);
            end
            alu_pkg::op_word_increment, alu_pkg::op_word_decrement: begin
               st_nxt.result = (op == alu_pkg::op_word_increment) ?
                  operand_a + 16'h0001 : operand_a - 16'h0001;
               st_nxt.wr_pair = (src == alu_pkg::src_reg);
               st_nxt.wr_mem = (src != alu_pkg::src_reg);
            end
            alu_pkg::op_logical_right_shift, alu_pkg::op_left_shift,
            alu_pkg::op_arith_right_shift: begin
               b = operand_a[7:0];
               for (int i = 0; i < (1 << count_w) - 1; i++) begin
                  if (i < int'(shift_count)) begin
                     if (op == alu_pkg::op_left_shift) begin
                        c = b[7];
                        b = {b[6:0], 1'b0};
                     end else begin
                        c = b[0];
                        b = {(op == alu_pkg::op_arith_right_shift) & b[7],
                           b[7:1]};
                     end
                  end
               end
               st_nxt.result = {8'h00, b};
               st_nxt.cy = c;
               st_nxt.wr_acc = 1'b1;
            end
            alu_pkg::op_word_logical_right_shift, alu_pkg::op_word_left_shift,
            alu_pkg::op_word_arith_right_shift: begin
               v = operand_a;
               for (int i = 0; i < (1 << count_w) - 1; i++) begin
                  if (i < int'(shift_count)) begin
                     if (op == alu_pkg::op_word_left_shift) begin
                        c = v[15];
                        v = {v[14:0], 1'b0};
                     end else begin
                        c = v[0];
                        v = {(op == alu_pkg::op_word_arith_right_shift) &
                           v[15], v[15:1]};
                     end
                  end
               end
               st_nxt.result = v;
               st_nxt.cy = c;
               st_nxt.wr_pair = 1'b1;
            end
            default: begin
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b0;
            end
         endcase
      end
      if (!nrst) begin
         st_nxt = '0;
         st_nxt.result = alu_pkg::result_reset;
         st_nxt.count = alu_pkg::count_reset;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   assign busy = st_r.busy;
   assign done = st_r.done;
   assign result = st_r.result;
   assign write_accumulator = st_r.wr_acc;
   assign write_memory = st_r.wr_mem;
   assign write_pair = st_r.wr_pair;
   assign zero_flag = st_r.z;
   assign half_carry_flag = st_r.ac;
   assign carry_flag = st_r.cy;
   assign operand_address = st_r.addr;

endmodule : alu_datapath
`default_nettype wire

// ===== alu_datapath_props.sv
// alu_datapath_props: port assertions of the datapath
// assumes: bound into alu_datapath
`timescale 1ns/1ps
`default_nettype none
module alu_datapath_props #(
   parameter int data_w = 8,
   parameter int count_w = 4
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic start,
   input wire alu_pkg::alu_op_t op,
   input wire alu_pkg::alu_src_t src,
   input wire logic [15:0] operand_a,
   input wire logic [15:0] operand_b,
   input wire logic [count_w-1:0] shift_count,
   input wire logic zero_flag_in,
   input wire logic half_carry_flag_in,
   input wire logic carry_flag_in,
   input wire logic [3:0] upper_bank_register,
   input wire logic [15:0] address_offset,
   input wire logic busy,
   input wire logic done,
   input wire logic [15:0] result,
   input wire logic write_accumulator,
   input wire logic write_memory,
   input wire logic write_pair,
   input wire logic zero_flag,
   input wire logic half_carry_flag,
   input wire logic carry_flag,
   input wire logic [19:0] operand_address
);
   default clocking dclk @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   sequence took;
      start && !busy;
   endsequence
   sequence two_clk;
      !done ##1 done;
   endsequence
   ////////////////////////////////////////
   reset_clear_a: assert property (disable iff (1'b0) !nrst |=> !busy &&
      !done && result == 16'h0000 && !carry_flag && !write_pair)
      else $error("reset not clear");
   sub_imm_a: assert property (
      took ##0 (op == alu_pkg::op_subtract_with_borrow &&
      src == alu_pkg::src_imm) |=> done && result[7:0] ==
      8'($past(operand_a) - $past(operand_b) - 16'($past(carry_flag_in))))
      else $error("borrow sub wrong");
   logic_keep_a: assert property (
      took ##0 (op inside {[alu_pkg::op_and : alu_pkg::op_xor]}) |=>
      half_carry_flag == $past(half_carry_flag_in) &&
      carry_flag == $past(carry_flag_in) && zero_flag == (result == 16'h0000))
      else $error("logic flags");
   zero_cmp_a: assert property (
      took ##0 (op == alu_pkg::op_compare_with_zero) |=> !half_carry_flag &&
      !carry_flag && zero_flag == (($past(operand_a) & 16'h00ff) == 16'h0000))
      else $error("cmp zero flags");
   cmp_nowrite_a: assert property (
      took ##0 (op inside {[alu_pkg::op_compare : alu_pkg::op_index_compare],
      alu_pkg::op_word_compare}) |=> !write_accumulator && !write_memory &&
      !write_pair) else $error("compare wrote");
   flash_four_a: assert property (
      took ##0 (src == alu_pkg::src_flash && op inside
      {[alu_pkg::op_subtract_with_borrow : alu_pkg::op_index_compare]})
      |=> !done [*3] ##1 done) else $error("flash not 4");
   ext_word_a: assert property (
      took ##0 (op == alu_pkg::op_word_add && src == alu_pkg::src_ext_flash)
      |=> !done [*5] ##1 done) else $error("ext word add not 6");
   mul_keep_a: assert property (
      took ##0 (op == alu_pkg::op_unsigned_multiply) |=>
      (zero_flag == $past(zero_flag_in) && carry_flag == $past(carry_flag_in)
      && half_carry_flag == $past(half_carry_flag_in)) ##0 two_clk)
      else $error("multiply wrong");
   byte_shift_a: assert property (
      took ##0 (op inside {alu_pkg::op_logical_right_shift,
      alu_pkg::op_left_shift}) |=> done && !busy)
      else $error("byte shift slow");
   word_shift_a: assert property (
      took ##0 (op inside {[alu_pkg::op_word_logical_right_shift :
      alu_pkg::op_word_arith_right_shift]}) |=> two_clk)
      else $error("word shift slow");
   ext_addr_a: assert property (
      took ##0 (src inside {alu_pkg::src_ext_ram, alu_pkg::src_ext_flash})
      |=> operand_address == {$past(upper_bank_register),
      $past(address_offset)}) else $error("bank address");
endmodule : alu_datapath_props
bind alu_datapath alu_datapath_props #(.data_w(data_w), .count_w(count_w))
   alu_datapath_props_i (.sys_clk, .nrst, .start, .op, .src, .operand_a,
   .operand_b, .shift_count, .zero_flag_in, .half_carry_flag_in,
   .carry_flag_in, .upper_bank_register, .address_offset, .busy, .done,
   .result, .write_accumulator, .write_memory, .write_pair, .zero_flag,
   .half_carry_flag, .carry_flag, .operand_address);
`default_nettype wire

// ===== alu_pkg.sv
// alu_pkg: constants and types of the datapath
// assumes: one cpu clock, ops from the sequencer
package alu_pkg;

   // operation codes
   typedef enum logic [4:0] {
      op_subtract_with_borrow,
      op_and,
      op_or,
      op_xor,
      op_compare,
      op_compare_with_zero,
      op_index_compare,
      op_word_add,
      op_word_subtract,
      op_word_compare,
      op_unsigned_multiply,
      op_increment,
      op_decrement,
      op_word_increment,
      op_word_decrement,
      op_logical_right_shift,
      op_left_shift,
      op_arith_right_shift,
      op_word_logical_right_shift,
      op_word_left_shift,
      op_word_arith_right_shift
   } alu_op_t;

   // operand source form
   typedef enum logic [2:0] {
      src_imm,
      src_reg,
      src_saddr_imm,
      src_ram,
      src_flash,
      src_ext_ram,
      src_ext_flash
   } alu_src_t;

   // clock counts
   localparam logic [2:0] cyc_byte_ram = 3'h1;
   localparam logic [2:0] cyc_byte_flash = 3'h4;
   localparam logic [2:0] cyc_byte_ext_ram = 3'h2;
   localparam logic [2:0] cyc_byte_ext_flash = 3'h5;
   localparam logic [2:0] cyc_saddr_imm = 3'h2;
   localparam logic [2:0] cyc_word_reg = 3'h2;
   localparam logic [2:0] cyc_word_ram = 3'h2;
   localparam logic [2:0] cyc_word_flash = 3'h5;
   localparam logic [2:0] cyc_word_ext_ram = 3'h3;
   localparam logic [2:0] cyc_word_ext_flash = 3'h6;
   localparam logic [2:0] cyc_word_incdec_reg = 3'h2;
   localparam logic [2:0] cyc_word_incdec_mem = 3'h4;
   localparam logic [2:0] cyc_word_incdec_ext = 3'h5;
   localparam logic [2:0] cyc_multiply = 3'h2;
   localparam logic [2:0] cyc_byte_shift = 3'h1;
   localparam logic [2:0] cyc_word_shift = 3'h2;

   // reset values and zero byte
   localparam logic [15:0] result_reset = 16'h0000;
   localparam logic [2:0] count_reset = 3'h0;
   localparam logic [7:0] zero_byte = 8'h00;

   // half carry taps out of bit 3
   localparam int half_bit = 4;

endpackage : alu_pkg

// ===== op_issuer.sv
// op_issuer: sequencer model, one operation at a time
// assumes: drives at the falling edge
`timescale 1ns/1ps
`default_nettype none
module op_issuer #(
   parameter logic [3:0] bank_val = 4'h9
) (
   input wire logic sys_clk,
   input wire logic busy,
   input wire logic done,
   output logic start,
   output var alu_pkg::alu_op_t op,
   output var alu_pkg::alu_src_t src,
   output logic [15:0] operand_a,
   output logic [15:0] operand_b,
   output logic [3:0] shift_count,
   output logic zero_flag_in,
   output logic half_carry_flag_in,
   output logic carry_flag_in,
   output logic [3:0] upper_bank_register,
   output logic [15:0] address_offset
);
   initial begin
      op = alu_pkg::op_and;
      src = alu_pkg::src_imm;
      {start, operand_a, operand_b, shift_count, upper_bank_register} = '0;
      {zero_flag_in, half_carry_flag_in, carry_flag_in, address_offset} = '0;
   end
   task automatic issue(input alu_pkg::alu_op_t o, input alu_pkg::alu_src_t s,
      input logic [15:0] a, input logic [15:0] b, input logic [3:0] n,
      input logic [2:0] f, output int cyc);
      @(negedge sys_clk);
      cyc = 0;
      while (busy !== 1'b0 && cyc < 10) begin
         @(negedge sys_clk);
         cyc++;
      end
      start = 1'b1;
      op = o;
      src = s;
      {operand_a, operand_b, shift_count, address_offset} = {a, b, n, a};
      {zero_flag_in, half_carry_flag_in, carry_flag_in} = f;
      upper_bank_register = bank_val;
      @(negedge sys_clk);
      // scramble qualifiers once start drops
      start = 1'b0;
      {operand_a, operand_b, shift_count} = ~{a, b, n};
      {zero_flag_in, half_carry_flag_in, carry_flag_in} = ~f;
      {upper_bank_register, address_offset} = ~{bank_val, a};
      cyc = 1;
      while (done !== 1'b1 && cyc < 12) begin
         @(negedge sys_clk);
         cyc++;
      end
   endtask : issue
endmodule : op_issuer
`default_nettype wire

// ===== test_cpu_alu_arith_logic_shift.sv
// test_cpu_alu_arith_logic_shift: self-checking bench for alu_datapath
// assumes: op_issuer drives the inputs
`timescale 1ns/1ps
`default_nettype none
module test_cpu_alu_arith_logic_shift;
   logic sys_clk, nrst, start, busy, done;
   alu_pkg::alu_op_t op;
   alu_pkg::alu_src_t src;
   logic [15:0] operand_a, operand_b, address_offset, result;
   logic [3:0] shift_count, upper_bank_register, sc;
   logic zero_flag_in, half_carry_flag_in, carry_flag_in;
   logic write_accumulator, write_memory, write_pair;
   logic zero_flag, half_carry_flag, carry_flag;
   logic [19:0] operand_address;
   int num_errors, num_checks;
   alu_datapath alu_datapath_i (.sys_clk, .nrst,
      .start, .op, .src, .operand_a, .operand_b, .shift_count,
      .zero_flag_in, .half_carry_flag_in, .carry_flag_in,
      .upper_bank_register, .address_offset, .busy, .done, .result,
      .write_accumulator, .write_memory, .write_pair, .zero_flag,
      .half_carry_flag, .carry_flag, .operand_address);
   op_issuer op_issuer_i (.sys_clk, .busy, .done, .start,
      .op, .src, .operand_a, .operand_b, .shift_count, .zero_flag_in,
      .half_carry_flag_in, .carry_flag_in, .upper_bank_register,
      .address_offset);
   ////////////////////////////////////////
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // flags: {zero, half carry, carry}
   task automatic run(input alu_pkg::alu_op_t o, input alu_pkg::alu_src_t s,
      input logic [15:0] a, input logic [15:0] b, input logic [2:0] f,
      input logic [15:0] er, input logic [2:0] ef, input int ec);
      int c;
      op_issuer_i.issue(o, s, a, b, sc, f, c);
      if (!(o inside {[alu_pkg::op_compare : alu_pkg::op_index_compare],
         alu_pkg::op_word_compare}))
         chk(20'(result), 20'(er));
      chk(20'({zero_flag, half_carry_flag, carry_flag}), 20'(ef));
      chk(20'(c), 20'(ec));
   endtask : run
   function automatic logic [19:0] dest();
      return 20'({write_accumulator, write_memory, write_pair});
   endfunction : dest
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////
   task automatic borrow_test();
      run(alu_pkg::op_subtract_with_borrow, alu_pkg::src_imm, 16'h0010,
         16'h0001, 3'h1, 16'h000e, 3'h2, 1);
      run(alu_pkg::op_subtract_with_borrow, alu_pkg::src_imm, 16'h0005,
         16'h0004, 3'h1, 16'h0000, 3'h4, 1);
      run(alu_pkg::op_subtract_with_borrow, alu_pkg::src_saddr_imm, 16'h0000,
         16'h0000, 3'h1, 16'h00ff, 3'h3, 2);
      chk(dest(), 20'h00002);
   endtask : borrow_test
   task automatic logic_test();
      run(alu_pkg::op_and, alu_pkg::src_imm, 16'h00f0, 16'h000f, 3'h3,
         16'h0000, 3'h7, 1);
      run(alu_pkg::op_or, alu_pkg::src_ext_ram, 16'h00a0, 16'h0005, 3'h7,
         16'h00a5, 3'h3, 2);
      chk(operand_address, 20'h900a0);
      run(alu_pkg::op_xor, alu_pkg::src_flash, 16'h00ff, 16'h00ff, 3'h0,
         16'h0000, 3'h4, 4);
      chk(operand_address, 20'h000ff);
      run(alu_pkg::op_and, alu_pkg::src_ext_flash, 16'h5a3c, 16'h00ff, 3'h2,
         16'h003c, 3'h2, 5);
   endtask : logic_test
   task automatic compare_test();
      run(alu_pkg::op_compare, alu_pkg::src_imm, 16'h0020, 16'h0021, 3'h4,
         16'h0000, 3'h3, 1);
      chk(dest(), 20'h00000);
      run(alu_pkg::op_compare_with_zero, alu_pkg::src_reg, 16'h0000, 16'h0000,
         3'h3, 16'h0000, 3'h4, 1);
      run(alu_pkg::op_compare_with_zero, alu_pkg::src_reg, 16'h0080, 16'h0000,
         3'h7, 16'h0000, 3'h0, 1);
      run(alu_pkg::op_index_compare, alu_pkg::src_ram, 16'h0010, 16'h0010,
         3'h3, 16'h0000, 3'h4, 1);
      run(alu_pkg::op_index_compare, alu_pkg::src_flash, 16'h0010, 16'h0011,
         3'h4, 16'h0000, 3'h3, 4);
   endtask : compare_test
   task automatic word_test();
      run(alu_pkg::op_word_add, alu_pkg::src_ram, 16'hffff, 16'h0001, 3'h0,
         16'h0000, 3'h7, 2);
      chk(dest(), 20'h00001);
      run(alu_pkg::op_word_add, alu_pkg::src_ext_flash, 16'h0f0f, 16'h00f1,
         3'h0, 16'h1000, 3'h2, 6);
      run(alu_pkg::op_word_add, alu_pkg::src_ext_ram, 16'h1234, 16'h0001,
         3'h7, 16'h1235, 3'h0, 3);
      run(alu_pkg::op_word_subtract, alu_pkg::src_ram, 16'h0001, 16'h0002,
         3'h4, 16'hffff, 3'h3, 2);
      run(alu_pkg::op_word_compare, alu_pkg::src_imm, 16'h1234, 16'h1234,
         3'h3, 16'h0000, 3'h4, 2);
      chk(dest(), 20'h00000);
      run(alu_pkg::op_unsigned_multiply, alu_pkg::src_reg, 16'h12ff, 16'h34ff,
         3'h5, 16'hfe01, 3'h5, 2);
      chk(dest(), 20'h00001);
   endtask : word_test
   task automatic incdec_test();
      run(alu_pkg::op_increment, alu_pkg::src_reg, 16'h00ff, 16'h0000, 3'h0,
         16'h0000, 3'h6, 1);
      run(alu_pkg::op_decrement, alu_pkg::src_reg, 16'h0000, 16'h0000, 3'h1,
         16'h00ff, 3'h3, 1);
      run(alu_pkg::op_word_increment, alu_pkg::src_reg, 16'hffff, 16'h0000,
         3'h2, 16'h0000, 3'h2, 2);
      run(alu_pkg::op_word_decrement, alu_pkg::src_ram, 16'h0000, 16'h0000,
         3'h5, 16'hffff, 3'h5, 4);
   endtask : incdec_test
   task automatic shift_test();
      sc = 4'h3;
      run(alu_pkg::op_logical_right_shift, alu_pkg::src_reg, 16'hff8d,
         16'h0000, 3'h6, 16'h0011, 3'h7, 1);
      sc = 4'h4;
      run(alu_pkg::op_left_shift, alu_pkg::src_reg, 16'h0018, 16'h0000, 3'h0,
         16'h0080, 3'h1, 1);
      sc = 4'h2;
      run(alu_pkg::op_arith_right_shift, alu_pkg::src_reg, 16'h0082, 16'h0000,
         3'h0, 16'h00e0, 3'h1, 1);
      sc = 4'h1;
      run(alu_pkg::op_word_logical_right_shift, alu_pkg::src_reg, 16'h8001,
         16'h0000, 3'h0, 16'h4000, 3'h1, 2);
      sc = 4'hf;
      run(alu_pkg::op_word_left_shift, alu_pkg::src_reg, 16'h8001, 16'h0000,
         3'h7, 16'h8000, 3'h6, 2);
      run(alu_pkg::op_word_arith_right_shift, alu_pkg::src_reg, 16'h8000,
         16'h0000, 3'h1, 16'hffff, 3'h0, 2);
   endtask : shift_test
   task automatic reset_test();
      @(negedge sys_clk);
      nrst = 1'b0;
      @(negedge sys_clk);
      chk({result, done, busy, carry_flag, write_pair}, 20'h00000);
      chk(operand_address, 20'h00000);
      nrst = 1'b1;
   endtask : reset_test
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // traffic takes about 100 cycles
   initial begin
      #200000;
      num_errors++;
      wrap_up();
   end
   initial begin
      sc = 4'h0;
      nrst = 1'b0;
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      borrow_test();
      logic_test();
      compare_test();
      word_test();
      incdec_test();
      shift_test();
      reset_test();
      wrap_up();
   end
endmodule : test_cpu_alu_arith_logic_shift
`default_nettype wire
